// ==== shared/dmacc_consts.svh ====
// Register offsets, field positions, reset values and kind codes of the DMA channel.
// Assumes it is included by its bare name from design files; it holds definitions only.
`ifndef DMACC_CONSTS_SVH
`define DMACC_CONSTS_SVH

// Register byte offsets on the register bus.
`define DMACC_OFF_CTRL      8'h30
`define DMACC_OFF_SRC       8'h34
`define DMACC_OFF_DST       8'h38
`define DMACC_OFF_COUNT     8'h3C
`define DMACC_OFF_STATUS    8'h50
`define DMACC_OFF_MASK      8'h54
`define DMACC_OFF_PROGRESS  8'h58

// Control field positions and reset values.
`define DMACC_CTRL_GO       0
`define DMACC_CTRL_RELOAD   1
`define DMACC_CTRL_SRC_LSB  4
`define DMACC_CTRL_DST_LSB  8
`define DMACC_CTRL_WSEL     12
`define DMACC_PROG_BUSY     31
`define DMACC_RESET_WORD    32'h0000_0000

// Event bits of the status and mask registers.
`define DMACC_EVT_DONE      0
`define DMACC_EVT_ERROR     1
`define DMACC_EVT_ABORT     2

// Kind codes that the channel treats specially.
`define DMACC_KIND_MEMORY   4'h0
`define DMACC_KIND_BB_RAM   4'h1
`define DMACC_DST_MODEM     4'h2
`define DMACC_DST_I2S_TX    4'h5
`define DMACC_DST_SPI1_TX   4'h9
`define DMACC_DST_LCD       4'hC
`define DMACC_DST_SPI0_TX   4'hD
`define DMACC_SRC_MODEM     4'h4
`define DMACC_SRC_ADC       4'h5
`define DMACC_SRC_SPI1_RX   4'h9
`define DMACC_SRC_I2S_RX    4'hA
`define DMACC_SRC_SPI0_RX   4'hD

// One bit per legal kind code, indexed by the code.
`define DMACC_DST_LEGAL     16'h33EF
`define DMACC_SRC_LEGAL     16'h27FB

// Bytes per beat.
`define DMACC_BYTES_8       3'h1
`define DMACC_BYTES_16      3'h2
`define DMACC_BYTES_24      3'h3
`define DMACC_BYTES_32      3'h4

`endif

// ==== shared/dmacc_pkg.sv ====
// Types shared by the DMA channel and its surroundings.
// Assumes the constants header supplies the numeric values.
package dmacc_pkg;

  // Channel sequencer states, one-hot.
  typedef enum logic [2:0] {
    DMACC_IDLE  = 3'b001,
    DMACC_READ  = 3'b010,
    DMACC_WRITE = 3'b100
  } dmacc_state_t;

  // Software-visible control fields.
  typedef struct packed {
    logic       width_sel;
    logic [3:0] dst_kind;
    logic [3:0] src_kind;
    logic       reload;
    logic       go;
  } dmacc_ctrl_t;

  // One beat request towards a source or a destination.
  typedef struct packed {
    logic [18:0] addr;
    logic [2:0]  bytes;
    logic [3:0]  kind;
  } dmacc_beat_t;

endpackage

// ==== design/dmacc_channel.sv ====
// One DMA channel: control, address and count registers, a beat sequencer and events.
// Assumes a single clock, Avalon-MM register access, and source and sink ports that
// acknowledge each beat request with a one-cycle pulse.
//
// Function
// (R1) A destination of LCD, I2S transmit, SPI or modem kind counts one per write.
// (R2) A source of ADC, SPI or modem kind counts one per read.
// (R3) Any other pairing counts the transfer in bytes moved.
// (R4) I2S beats are 16 bits with the width bit clear and 24 bits with it set.
// (R5) SPI1 beats are 8 bits with the width bit clear and 32 bits with it set.
// (R6) Destination kind sits in control bits 11:8 and its reserved codes are refused.
// (R7) Source kind sits in control bits 7:4 and its reserved codes are refused.
// (R8) With reload set the channel relatches its registers and restarts after completion.
// (R9) A rising go bit latches addresses, kinds and width and starts the transfer.
// (R10) The channel clears go itself on completion or on a transfer error.
// (R11) Writing go to zero during a transfer aborts it.
// (R12) Address registers hold 19 bits and read zero above them.
// (R13) With 16-bit beats address bit 0 is ignored.
// (R14) With 32-bit beats the low address bits below the word are ignored.
// (R15) Software leaves the registers alone while go is set and programs legal kinds.
`timescale 1ns/1ns
`include "dmacc_consts.svh"

module dmacc_channel #(
  parameter int CNT_W = 18
) (
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic [7:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  output logic                      irq,
  output logic                      busy,
  output logic                      rd_req,
  output dmacc_pkg::dmacc_beat_t    rd_beat,
  input  wire logic                 rd_ack,
  input  wire logic [31:0]          rd_data,
  output logic                      wr_req,
  output dmacc_pkg::dmacc_beat_t    wr_beat,
  output logic      [31:0]          wr_data,
  input  wire logic                 wr_ack,
  input  wire logic                 xfer_error
);

  // Destination kinds whose count is a number of FIFO writes.
  function automatic logic dst_fifo_counted(input logic [3:0] k);
    dst_fifo_counted = (k == `DMACC_DST_MODEM) || (k == `DMACC_DST_I2S_TX) ||
                       (k == `DMACC_DST_SPI1_TX) || (k == `DMACC_DST_LCD) ||
                       (k == `DMACC_DST_SPI0_TX);
  endfunction

  // Source kinds whose count is a number of FIFO reads.
  function automatic logic src_fifo_counted(input logic [3:0] k);
    src_fifo_counted = (k == `DMACC_SRC_MODEM) || (k == `DMACC_SRC_ADC) ||
                       (k == `DMACC_SRC_SPI1_RX) || (k == `DMACC_SRC_SPI0_RX);
  endfunction

  // Bytes per beat from the kinds and the width select bit.
  function automatic logic [2:0] beat_size(input logic [3:0] s, input logic [3:0] d,
                                           input logic w);
    if ((s == `DMACC_SRC_I2S_RX) || (d == `DMACC_DST_I2S_TX)) begin
      beat_size = w ? `DMACC_BYTES_24 : `DMACC_BYTES_16;
    end else if ((s == `DMACC_SRC_SPI1_RX) || (d == `DMACC_DST_SPI1_TX)) begin
      beat_size = w ? `DMACC_BYTES_32 : `DMACC_BYTES_8;
    end else begin
      beat_size = `DMACC_BYTES_8;
    end
  endfunction

  // Drops the address bits that a wide beat ignores.
  function automatic logic [18:0] align(input logic [18:0] a, input logic [2:0] b);
    if (b == `DMACC_BYTES_16) begin
      align = {a[18:1], 1'b0};
    end else if (b == `DMACC_BYTES_32) begin
      align = {a[18:2], 2'b00};
    end else begin
      align = a;
    end
  endfunction

  // Memory-like kinds step their address; FIFO kinds keep it fixed.
  function automatic logic kind_steps(input logic [3:0] k);
    kind_steps = (k == `DMACC_KIND_MEMORY) || (k == `DMACC_KIND_BB_RAM);
  endfunction

  // Byte-lane merge of a bus write into a register word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        merge[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction

  // Programmed registers.
  dmacc_pkg::dmacc_ctrl_t  ctrl;
  logic [18:0]             src_addr;
  logic [18:0]             dst_addr;
  logic [CNT_W-1:0]        count_reg;
  logic [2:0]              status;
  logic [2:0]              mask;
  logic                    served;

  // Working copies that the running transfer uses.
  dmacc_pkg::dmacc_state_t state;
  dmacc_pkg::dmacc_state_t next_state;
  logic [18:0]             cur_src;
  logic [18:0]             cur_dst;
  logic [CNT_W-1:0]        remaining;
  logic [2:0]              bytes_r;
  logic [2:0]              dec_r;
  logic [3:0]              src_kind_r;
  logic [3:0]              dst_kind_r;
  logic                    wsel_r;
  logic [31:0]             data_r;

  // Bus handshake: every access waits one cycle, then completes.
  wire logic        acc      = avs_read | avs_write;
  wire logic        take     = acc & served;
  wire logic        wr_take  = take & avs_write;
  wire logic        rd_take  = take & avs_read;
  wire logic        sel_ctrl = avs_address == `DMACC_OFF_CTRL;
  wire logic        sel_src  = avs_address == `DMACC_OFF_SRC;
  wire logic        sel_dst  = avs_address == `DMACC_OFF_DST;
  wire logic        sel_cnt  = avs_address == `DMACC_OFF_COUNT;
  wire logic        sel_stat = avs_address == `DMACC_OFF_STATUS;
  wire logic        sel_mask = avs_address == `DMACC_OFF_MASK;
  wire logic        sel_prog = avs_address == `DMACC_OFF_PROGRESS;
  assign avs_waitrequest = acc & ~served;

  // Register words as software sees them; reserved bits read zero.
  wire logic [31:0] ctrl_word = {19'h0_0000, ctrl.width_sel, ctrl.dst_kind, ctrl.src_kind,
                                 2'b00, ctrl.reload, ctrl.go};
  wire logic [31:0] src_word  = {13'h0000, src_addr};
  wire logic [31:0] dst_word  = {13'h0000, dst_addr};
  wire logic [31:0] cnt_word  = 32'(count_reg);
  wire logic [31:0] rd_mux    = sel_ctrl ? ctrl_word :
                                sel_src  ? src_word :
                                sel_dst  ? dst_word :
                                sel_cnt  ? cnt_word :
                                sel_stat ? {29'h0000_0000, status} :
                                sel_mask ? {29'h0000_0000, mask} :
                                sel_prog ? {busy, 31'(remaining)} :
                                `DMACC_RESET_WORD;

  // Write data merged under byte enables.
  wire logic [31:0] ctrl_wval = merge(ctrl_word, avs_writedata, avs_byteenable);
  wire logic [31:0] src_wval  = merge(src_word, avs_writedata, avs_byteenable);
  wire logic [31:0] dst_wval  = merge(dst_word, avs_writedata, avs_byteenable);
  wire logic [31:0] cnt_wval  = merge(cnt_word, avs_writedata, avs_byteenable);
  wire logic [31:0] msk_wval  = merge({29'h0000_0000, mask}, avs_writedata, avs_byteenable);
  wire logic        ctrl_write = wr_take & sel_ctrl;

  // Go edge, abort, and the configuration that a launch latches.
  wire logic        start_req = ctrl_write & ctrl_wval[`DMACC_CTRL_GO] & ~ctrl.go;  // see (R9)
  wire logic        abort_req = ctrl_write & ~ctrl_wval[`DMACC_CTRL_GO] & busy;     // see (R11)
  wire logic [31:0] cfg_word  = start_req ? ctrl_wval : ctrl_word;
  wire logic [3:0]  cfg_src   = cfg_word[`DMACC_CTRL_SRC_LSB +: 4];
  wire logic [3:0]  cfg_dst   = cfg_word[`DMACC_CTRL_DST_LSB +: 4];
  wire logic        cfg_wsel  = cfg_word[`DMACC_CTRL_WSEL];
  wire logic [2:0]  cfg_bytes = beat_size(cfg_src, cfg_dst, cfg_wsel);            // see (R4) (R5)
  wire logic        cfg_fifo  = dst_fifo_counted(cfg_dst) | src_fifo_counted(cfg_src);
  wire logic        kinds_ok  = 1'(`DMACC_DST_LEGAL >> cfg_dst) & 1'(`DMACC_SRC_LEGAL >> cfg_src);

  // Beat completion and the launch of a new pass.
  wire logic        beat_done = (state == dmacc_pkg::DMACC_WRITE) & wr_ack & ~xfer_error;
  wire logic        last_beat = beat_done & (remaining <= CNT_W'(dec_r)) & ~abort_req;
  wire logic        reload_go = last_beat & ctrl.reload;                           // see (R8)
  wire logic        launch    = start_req | reload_go;
  wire logic        launch_bad   = launch & ~kinds_ok;                             // see (R6) (R7)
  wire logic        launch_empty = launch & kinds_ok & (count_reg == '0);
  wire logic        launch_run   = launch & kinds_ok & (count_reg != '0);
  wire logic        run_error = xfer_error & busy & ~abort_req;

  // Events and the hardware clear of go.
  wire logic [2:0]  events = {abort_req, launch_bad | run_error, last_beat | launch_empty};
  wire logic        go_clear = (last_beat & ~ctrl.reload) | launch_bad | launch_empty |
                               run_error;                                          // see (R10)
  wire logic [2:0]  stat_clr = (rd_take & sel_stat) ? avs_readdata[2:0] : 3'h0;

  // Beat ports are driven straight from the working registers.
  assign busy    = state != dmacc_pkg::DMACC_IDLE;
  assign rd_req  = state == dmacc_pkg::DMACC_READ;
  assign wr_req  = state == dmacc_pkg::DMACC_WRITE;
  assign rd_beat = '{addr: cur_src, bytes: bytes_r, kind: src_kind_r};
  assign wr_beat = '{addr: cur_dst, bytes: bytes_r, kind: dst_kind_r};
  assign wr_data = data_r;
  assign irq     = |(status & mask);

  // Sequencer: abort and errors return to idle before any beat progress.
  always_comb begin
    next_state = state;
    case (state)
      dmacc_pkg::DMACC_IDLE: begin
        if (launch_run) begin
          next_state = dmacc_pkg::DMACC_READ;
        end
      end
      dmacc_pkg::DMACC_READ: begin
        if (rd_ack) begin
          next_state = dmacc_pkg::DMACC_WRITE;
        end
      end
      dmacc_pkg::DMACC_WRITE: begin
        if (last_beat) begin
          next_state = launch_run ? dmacc_pkg::DMACC_READ : dmacc_pkg::DMACC_IDLE;
        end else if (beat_done) begin
          next_state = dmacc_pkg::DMACC_READ;
        end
      end
      default: begin
        next_state = dmacc_pkg::DMACC_IDLE;
      end
    endcase
    if (abort_req || run_error) begin
      next_state = dmacc_pkg::DMACC_IDLE;                                          // see (R11)
    end
  end

  // Bus access phase and read data, loaded in the waiting cycle.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      served       <= 1'b0;
      avs_readdata <= `DMACC_RESET_WORD;
    end else begin
      served <= acc & ~served;
      if (avs_read && !served) begin
        avs_readdata <= rd_mux;                                                    // see (R12)
      end
    end
  end

  // Control register; the hardware clear of go is applied after software writes.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl <= '0;
    end else begin
      if (ctrl_write) begin
        ctrl.go        <= ctrl_wval[`DMACC_CTRL_GO];
        ctrl.reload    <= ctrl_wval[`DMACC_CTRL_RELOAD];
        ctrl.src_kind  <= ctrl_wval[`DMACC_CTRL_SRC_LSB +: 4];
        ctrl.dst_kind  <= ctrl_wval[`DMACC_CTRL_DST_LSB +: 4];
        ctrl.width_sel <= ctrl_wval[`DMACC_CTRL_WSEL];
      end
      if (go_clear) begin
        ctrl.go <= 1'b0;                                                           // see (R10)
      end
    end
  end

  // Address, count and mask registers; only 19 address bits are stored.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      src_addr  <= 19'h0_0000;
      dst_addr  <= 19'h0_0000;
      count_reg <= '0;
      mask      <= 3'h0;
    end else if (wr_take) begin
      if (sel_src) begin
        src_addr <= src_wval[18:0];                                                // see (R12)
      end else if (sel_dst) begin
        dst_addr <= dst_wval[18:0];
      end else if (sel_cnt) begin
        count_reg <= cnt_wval[CNT_W-1:0];
      end else if (sel_mask) begin
        mask <= msk_wval[2:0];
      end
    end
  end

  // Sticky events; a read clears only what it reported, and a new set wins.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      status <= 3'h0;
    end else begin
      status <= (status & ~stat_clr) | events;
    end
  end

  // Latch on launch, then step the count and any memory-kind address once per finished beat.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state      <= dmacc_pkg::DMACC_IDLE;
      cur_src    <= 19'h0_0000;
      cur_dst    <= 19'h0_0000;
      remaining  <= '0;
      bytes_r    <= `DMACC_BYTES_8;
      dec_r      <= `DMACC_BYTES_8;
      src_kind_r <= 4'h0;
      dst_kind_r <= 4'h0;
      wsel_r     <= 1'b0;
    end else begin
      state <= next_state;
      if (launch_run) begin
        cur_src    <= align(src_addr, cfg_bytes);                                  // see (R9) (R13) (R14)
        cur_dst    <= align(dst_addr, cfg_bytes);
        remaining  <= count_reg;
        bytes_r    <= cfg_bytes;
        dec_r      <= cfg_fifo ? `DMACC_BYTES_8 : cfg_bytes;                       // see (R1) (R2) (R3)
        src_kind_r <= cfg_src;
        dst_kind_r <= cfg_dst;
        wsel_r     <= cfg_wsel;
      end else if (beat_done) begin
        remaining <= (remaining <= CNT_W'(dec_r)) ? '0 : remaining - CNT_W'(dec_r);
        if (kind_steps(src_kind_r)) begin
          cur_src <= cur_src + 19'(bytes_r);
        end
        if (kind_steps(dst_kind_r)) begin
          cur_dst <= cur_dst + 19'(bytes_r);
        end
      end
    end
  end

  // Data captured from the source beat and offered to the destination.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      data_r <= `DMACC_RESET_WORD;
    end else if (rd_req && rd_ack) begin
      data_r <= rd_data;
    end
  end

  // Checks on the channel's own behaviour.
  default clocking dmacc_cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  property p_fifo_write_count;
    beat_done && !last_beat && !launch_run && dst_fifo_counted(dst_kind_r)
      |=> remaining == $past(remaining) - CNT_W'(1);
  endproperty
  a_fifo_write_count: assert property (p_fifo_write_count) else $error("write count step wrong"); // see (R1)

  property p_fifo_read_count;
    beat_done && !last_beat && !launch_run && src_fifo_counted(src_kind_r)
      |=> remaining == $past(remaining) - CNT_W'(1);
  endproperty
  a_fifo_read_count: assert property (p_fifo_read_count) else $error("read count step wrong"); // see (R2)

  property p_byte_count;
    beat_done && !last_beat && !launch_run &&
      !dst_fifo_counted(dst_kind_r) && !src_fifo_counted(src_kind_r)
      |=> remaining == $past(remaining) - CNT_W'($past(bytes_r));
  endproperty
  a_byte_count: assert property (p_byte_count) else $error("byte count step wrong"); // see (R3)

  property p_i2s_width;
    rd_req && (src_kind_r == `DMACC_SRC_I2S_RX || dst_kind_r == `DMACC_DST_I2S_TX)
      |-> bytes_r == (wsel_r ? `DMACC_BYTES_24 : `DMACC_BYTES_16);
  endproperty
  a_i2s_width: assert property (p_i2s_width) else $error("I2S beat width wrong"); // see (R4)

  property p_spi_width;
    rd_req && (src_kind_r == `DMACC_SRC_SPI1_RX || dst_kind_r == `DMACC_DST_SPI1_TX) &&
      src_kind_r != `DMACC_SRC_I2S_RX && dst_kind_r != `DMACC_DST_I2S_TX
      |-> bytes_r == (wsel_r ? `DMACC_BYTES_32 : `DMACC_BYTES_8);
  endproperty
  a_spi_width: assert property (p_spi_width) else $error("SPI beat width wrong"); // see (R5)

  property p_kind_reject;
    start_req && !kinds_ok |=> !ctrl.go && !busy && status[`DMACC_EVT_ERROR];
  endproperty
  a_kind_reject: assert property (p_kind_reject) else $error("reserved kind not refused"); // see (R6) (R7)

  property p_reload_restart;
    last_beat && ctrl.reload && kinds_ok && count_reg != '0
      |=> rd_req && ctrl.go && remaining == $past(count_reg);
  endproperty
  a_reload_restart: assert property (p_reload_restart) else $error("reload did not restart"); // see (R8)

  property p_go_start;
    start_req && kinds_ok && count_reg != '0
      |=> rd_req && rd_beat.addr == align($past(src_addr), $past(cfg_bytes));
  endproperty
  a_go_start: assert property (p_go_start) else $error("go edge did not start"); // see (R9)

  property p_go_clear;
    (last_beat && !ctrl.reload) || run_error |=> !ctrl.go ##1 !ctrl.go || start_req;
  endproperty
  a_go_clear: assert property (p_go_clear) else $error("go not cleared at end"); // see (R10)

  property p_abort;
    abort_req |=> !busy && !rd_req && !wr_req && status[`DMACC_EVT_ABORT];
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not stop channel"); // see (R11)

  property p_addr_reserved;
    rd_take && (sel_src || sel_dst) |-> avs_readdata[31:19] == 13'h0000;
  endproperty
  a_addr_reserved: assert property (p_addr_reserved) else $error("address top bits set"); // see (R12)

  property p_align16;
    (rd_req || wr_req) && bytes_r == `DMACC_BYTES_16 |-> !rd_beat.addr[0] && !wr_beat.addr[0];
  endproperty
  a_align16: assert property (p_align16) else $error("16-bit beat misaligned"); // see (R13)

  property p_align32;
    (rd_req || wr_req) && bytes_r == `DMACC_BYTES_32
      |-> rd_beat.addr[1:0] == 2'b00 && wr_beat.addr[1:0] == 2'b00;
  endproperty
  a_align32: assert property (p_align32) else $error("32-bit beat misaligned"); // see (R14)

  // Main scenarios worth reaching.
  c_complete: cover property (last_beat && !ctrl.reload);
  c_reload:   cover property (reload_go && launch_run);
  c_abort:    cover property (abort_req && wr_req);
  c_error:    cover property (run_error);

endmodule

// ==== test/dmacc_far_end.sv ====
// Model of the peripheral FIFOs and memory behind the DMA channel beat ports.
// Assumes one clock; each ack is a one-cycle pulse, held back by stall or slow pace.
`timescale 1ns/1ns
module dmacc_far_end (
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire logic                    stall,
  input  wire logic                    slow,
  input  wire logic                    rd_req,
  output logic                         rd_ack,
  output logic [31:0]                  rd_data,
  input  wire logic                    wr_req,
  input  wire dmacc_pkg::dmacc_beat_t  wr_beat,
  input  wire logic [31:0]             wr_data,
  output logic                         wr_ack,
  output logic [31:0]                  n_rd,
  output logic [31:0]                  n_wr,
  output dmacc_pkg::dmacc_beat_t       last_beat,
  output logic [31:0]                  last_wdata,
  output logic [31:0]                  last_rdata
);
  logic tick;

  // Source data changes every cycle, so a late sample of it shows up as a mismatch.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      {tick, rd_ack, wr_ack, n_rd, n_wr} <= '0;
      rd_data <= 32'h5A5A_0000;
    end else begin
      tick <= ~tick;
      rd_data <= rd_data + 32'h0001_0003;
      rd_ack <= rd_req & ~rd_ack & ~stall & (~slow | tick);
      wr_ack <= wr_req & ~wr_ack & ~stall & (~slow | tick);
      if (rd_req & rd_ack) begin
        n_rd <= n_rd + 32'h0000_0001;
        last_rdata <= rd_data;
      end
      if (wr_req & wr_ack) begin
        n_wr <= n_wr + 32'h0000_0001;
        last_wdata <= wr_data;
        last_beat <= wr_beat;
      end
    end
  end
endmodule

// ==== test/dma_channel_config_test.sv ====
// Self-checking bench for the DMA channel: registers, transfers, events, abort.
// Assumes the far-end model answers beat requests; every wait is bounded.
`timescale 1ns/1ns
`include "dmacc_consts.svh"
`define CHK(g, e) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); \
  end \
end
module dma_channel_config_test;
  localparam logic [15:0] DST_OK = 16'h33EF;
  localparam logic [15:0] SRC_OK = 16'h27FB;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic        stall = 1'b0;
  logic        slow = 1'b0;
  logic        xfer_error = 1'b0;
  logic        avs_waitrequest, irq, busy, rd_req, rd_ack, wr_req, wr_ack;
  logic [31:0] avs_readdata, rd_data, wr_data, n_rd, n_wr, last_wdata, last_rdata, q, w0;
  dmacc_pkg::dmacc_beat_t rd_beat, wr_beat, last_beat;
  int          err_total = 0;
  int          n_checks = 0;
  int          i;

  dmacc_channel u_dmacc_channel (.mclk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .irq, .busy,
    .rd_req, .rd_beat, .rd_ack, .rd_data, .wr_req, .wr_beat, .wr_data, .wr_ack, .xfer_error);
  dmacc_far_end u_dmacc_far_end (.mclk, .rst_n, .stall, .slow, .rd_req, .rd_ack, .rd_data,
    .wr_req, .wr_beat, .wr_data, .wr_ack, .n_rd, .n_wr, .last_beat, .last_wdata, .last_rdata);

  // Clock of 10 ns period.
  always #5 mclk = ~mclk;

  task automatic stop_test();
    if (err_total == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic tmo();
    err_total++;
    stop_test();
  endtask

  // One register access, held until waitrequest is sampled low at a rising edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    if (avs_waitrequest !== 1'b0) tmo();
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    `CHK(q, e)
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (busy !== 1'b0 && n < 900);
    if (n >= 900) tmo();
  endtask

  // Launches one transfer from idle and checks beats, beat shape, go, status and irq.
  task automatic xfer(input logic [15:0] c, input logic [7:0] cnt, input logic [7:0] ew,
                      input logic [2:0] eb, input logic [7:0] ea, input logic [2:0] st);
    logic [31:0] r0;
    w0 = n_wr;
    r0 = n_rd;
    bus(1'b1, `DMACC_OFF_COUNT, {24'h00_0000, cnt});
    bus(1'b1, `DMACC_OFF_CTRL, {16'h0000, c});
    wait_idle();
    `CHK(n_wr - w0, {24'h00_0000, ew})
    `CHK(n_rd - r0, {24'h00_0000, ew})
    `CHK(last_wdata, last_rdata)
    if (eb != 3'h0) begin
      `CHK(last_beat.bytes, eb)
      `CHK(last_beat.addr, {11'h000, ea})
    end
    `CHK(irq, st[0])
    rchk(`DMACC_OFF_CTRL, {16'h0000, c[15:1], 1'b0});
    rchk(`DMACC_OFF_STATUS, {29'h0000_0000, st});
    // The read clears status at its closing edge; irq is looked at one edge later.
    @(posedge mclk);
    `CHK(irq, 1'b0)
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    for (i = 8'h30; i < 8'h64; i += 4) rchk(8'(i), 32'h0000_0000);
    bus(1'b1, 8'h60, 32'hFFFF_FFFF);
    rchk(8'h60, 32'h0000_0000);
    bus(1'b1, `DMACC_OFF_SRC, 32'hFFFF_FFFF);
    rchk(`DMACC_OFF_SRC, 32'h0007_FFFF);
    bus(1'b1, `DMACC_OFF_DST, 32'hFFFF_FFFF);
    rchk(`DMACC_OFF_DST, 32'h0007_FFFF);
    bus(1'b1, `DMACC_OFF_SRC, 32'h0000_0100);
    bus(1'b1, `DMACC_OFF_DST, 32'h0000_0013);
    bus(1'b1, `DMACC_OFF_MASK, 32'h0000_0001);
    xfer(16'h0001, 8'h04, 8'h04, 3'h1, 8'h16, 3'h1);
    xfer(16'h0C01, 8'h03, 8'h03, 3'h1, 8'h13, 3'h1);
    xfer(16'h0051, 8'h03, 8'h03, 3'h1, 8'h15, 3'h1);
    xfer(16'h0501, 8'h02, 8'h02, 3'h2, 8'h12, 3'h1);
    xfer(16'h1501, 8'h02, 8'h02, 3'h3, 8'h13, 3'h1);
    xfer(16'h0901, 8'h02, 8'h02, 3'h1, 8'h13, 3'h1);
    xfer(16'h1901, 8'h02, 8'h02, 3'h4, 8'h10, 3'h1);
    xfer(16'h10A1, 8'h06, 8'h02, 3'h3, 8'h16, 3'h1);
    xfer(16'h0001, 8'h00, 8'h00, 3'h0, 8'h00, 3'h1);
    for (i = 0; i < 16; i++) begin
      xfer({4'h0, 4'(i), 8'h01}, 8'h01, {7'h00, DST_OK[i]}, 3'h0, 8'h00,
           DST_OK[i] ? 3'h1 : 3'h2);
    end
    slow <= 1'b1;
    for (i = 0; i < 16; i++) begin
      xfer({8'h00, 4'(i), 4'h1}, 8'h01, {7'h00, SRC_OK[i]}, 3'h0, 8'h00,
           SRC_OK[i] ? 3'h1 : 3'h2);
    end
    slow <= 1'b0;
    stall <= 1'b1;
    bus(1'b1, `DMACC_OFF_COUNT, 32'h0000_0064);
    bus(1'b1, `DMACC_OFF_CTRL, 32'h0000_0001);
    bus(1'b1, `DMACC_OFF_CTRL, 32'h0000_0000);
    wait_idle();
    rchk(`DMACC_OFF_STATUS, 32'h0000_0004);
    bus(1'b1, `DMACC_OFF_CTRL, 32'h0000_0001);
    xfer_error <= 1'b1;
    @(posedge mclk);
    xfer_error <= 1'b0;
    wait_idle();
    rchk(`DMACC_OFF_CTRL, 32'h0000_0000);
    rchk(`DMACC_OFF_STATUS, 32'h0000_0002);
    stall <= 1'b0;
    bus(1'b1, `DMACC_OFF_COUNT, 32'h0000_0002);
    w0 = n_wr;
    bus(1'b1, `DMACC_OFF_CTRL, 32'h0000_0003);
    for (i = 0; i < 300 && n_wr - w0 < 32'h0000_0006; i++) @(negedge mclk);
    if (i >= 300) tmo();
    rchk(`DMACC_OFF_CTRL, 32'h0000_0003);
    bus(1'b1, `DMACC_OFF_CTRL, 32'h0000_0000);
    wait_idle();
    stop_test();
  end
endmodule
